//--- bgen_pkg.sv
// package: register map, field layout and carriers of the baud rate generator
package bgen_pkg;

  // ==========================================================================
  // register offsets (byte addresses on the apb bus)
  localparam logic [7:0] OFS_RELOAD = 8'h00;
  localparam logic [7:0] OFS_TX_SRC = 8'h04;
  localparam logic [7:0] OFS_RX_SRC = 8'h08;
  localparam logic [7:0] OFS_MODE1  = 8'h0C;
  localparam logic [7:0] OFS_STAT   = 8'h10;

  // ==========================================================================
  // reset values
  localparam logic [7:0] RST_RELOAD = 8'h00;
  localparam logic [7:0] RST_CSRC   = 8'h00;
  localparam logic [7:0] RST_MODE1  = 8'h00;

  // ==========================================================================
  // field positions
  localparam int EXP_LSB   = 0;
  localparam int SEL_LSB   = 4;
  localparam int ASYNC_BIT = 0;
  localparam int RATIO_LSB = 6;

  // ==========================================================================
  // timer and divider
  localparam int         MAX_EXP        = 9;
  localparam logic [3:0] EXP_LIMIT      = 4'h9;
  localparam logic [8:0] RELOAD_ZERO_PERIOD = 9'h100;
  localparam logic [8:0] TIMER_ONE          = 9'h001;
  localparam logic [7:0] RELOAD_FULL_RATE   = 8'h01;

  // ==========================================================================
  // clock source selections
  localparam logic [2:0] CS_EXT = 3'h0;
  localparam logic [2:0] CS_GEN = 3'h4;
  localparam logic [2:0] CS_PLL = 3'h6;

  // ==========================================================================
  // async clock ratio codes and terminal counts (ratio minus one)
  localparam logic [1:0] RATIO_16 = 2'h0;
  localparam logic [1:0] RATIO_32 = 2'h1;
  localparam logic [5:0] TERM_16  = 6'h0F;
  localparam logic [5:0] TERM_32  = 6'h1F;
  localparam logic [5:0] TERM_64  = 6'h3F;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } bgen_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } bgen_apb_rsp_s;

  typedef struct packed {
    logic clk;
    logic tick;
    logic bit_tick;
  } bgen_clk_s;

endpackage

//--- bgen_divider.sv
// power-of-two divider stage fed by reload timer pulses
`timescale 1ns/1ps
module bgen_divider
  import bgen_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_pulse,
  input  wire logic [3:0] i_exp,
  output logic            o_clk,
  output logic            o_tick
);

  logic [MAX_EXP-1:0] cnt_r;
  logic [MAX_EXP-1:0] cnt_nxt;
  logic [MAX_EXP-1:0] hit;
  logic [3:0]         exp_c;
  logic               clk_nxt;
  logic               tick_nxt;

  // exponents above nine are clamped rather than wrapped
  assign exp_c   = (i_exp > EXP_LIMIT) ? EXP_LIMIT : i_exp;
  assign cnt_nxt = i_pulse ? cnt_r + 1'b1 : cnt_r;

  // ==========================================================================
  // rising-edge detect: lower bits all ones, top used bit still low
  for (genvar k = 0; k < MAX_EXP; k++) begin : g_hit
    assign hit[k] = (k + 1 < int'(exp_c)) ? cnt_r[k] :
                    (k + 1 == int'(exp_c)) ? ~cnt_r[k] : 1'b1;
  end

  always_comb begin
    if (exp_c == 4'h0) begin
      clk_nxt  = i_pulse;
      tick_nxt = i_pulse;
    end else begin
      clk_nxt  = cnt_nxt[4'(exp_c - 4'h1)];
      tick_nxt = i_pulse && (&hit);
    end
  end

  // ==========================================================================
  // toggle chain as a free counter; bit n-1 is the square output of stage n
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_clk  <= 1'b0;
      o_tick <= 1'b0;
    end else begin
      o_clk  <= clk_nxt;
      o_tick <= tick_nxt;
    end
  end

  a_exp_zero_pass: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_exp == 4'h0 && i_pulse) |=> (o_tick && o_clk))
    else $error("undivided pulse did not pass through");

endmodule

//--- bgen_top.sv
// baud rate generator: reload timer, tx/rx dividers, routing and apb registers
// Function
// - output spans the system clock down to system clock over 2^17
// - full system clock rate never drives tx or rx data path, only pll
// - reload constant sits in an 8-bit software register loaded into timer
// - timer counts down each clock, one-cycle pulse when count equals one
// - reload constant zero means a period of 256 clocks
// - reload constant one pulses on every clock
// - timer pulses feed separate tx and rx dividers with own exponents
// - each output equals clock over constant over two to the exponent
// - tx and rx rates set independently from the common timer
// - tx and rx clock select fields route generator to each direction
// - receive generator output serves as bit clock or as digital pll clock, transmit generator output only as bit clock
// - targets from clock/100 to clock/2^17 land within half a percent
// - async mode scales bit rate by 1/16, 1/32 or 1/64 from mode register
//
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/1ps
module bgen_top
  import bgen_pkg::*;
(
  input  wire logic    i_clk,
  input  wire logic    i_rstn,
  input  bgen_apb_req_s i_apb,
  output bgen_apb_rsp_s o_apb,
  output bgen_clk_s    o_tx,
  output bgen_clk_s    o_rx,
  output logic         o_pll_tick
);

  // ==========================================================================
  // registers
  logic [7:0] reload_time_constant_r;
  logic [7:0] tx_clock_source_reg_r;
  logic [7:0] rx_clock_source_reg_r;
  logic [7:0] mode_reg_one_r;
  logic [31:0] prdata_r;
  logic        pslverr_r;

  logic       setup;
  logic       wr_en;
  logic       mapped;
  logic [31:0] rd_nxt;

  logic [8:0] timer_r;
  logic [8:0] period;
  logic       timer_pulse;

  logic [1:0][3:0] dir_exp;
  logic [1:0][2:0] dir_sel;
  logic [1:0]      div_clk;
  logic [1:0]      div_tick;
  logic [1:0]      fast;
  logic [1:0]      route;
  logic [1:0]      out_clk;
  logic [1:0]      out_tick;
  logic [1:0]      out_bit;
  logic            async_mode;
  logic [1:0]      async_clock_ratio;
  logic [5:0]      ratio_term;
  logic            pll_tick_r;

  // ==========================================================================
  // apb slave: zero wait states, read data captured in the setup cycle
  assign setup = i_apb.psel && !i_apb.penable;
  assign wr_en = i_apb.psel && i_apb.penable && i_apb.pwrite;

  always_comb begin
    mapped = 1'b1;
    rd_nxt = '0;
    if (i_apb.paddr == OFS_RELOAD) begin
      rd_nxt[7:0] = reload_time_constant_r;
    end else if (i_apb.paddr == OFS_TX_SRC) begin
      rd_nxt[7:0] = tx_clock_source_reg_r;
    end else if (i_apb.paddr == OFS_RX_SRC) begin
      rd_nxt[7:0] = rx_clock_source_reg_r;
    end else if (i_apb.paddr == OFS_MODE1) begin
      rd_nxt[7:0] = mode_reg_one_r;
    end else if (i_apb.paddr == OFS_STAT) begin
      // status is read-only; a write there answers with an error
      mapped      = !i_apb.pwrite;
      rd_nxt[8:0] = timer_r;
      rd_nxt[9]   = out_clk[0];
      rd_nxt[10]  = out_clk[1];
      rd_nxt[11]  = fast[0];
      rd_nxt[12]  = fast[1];
    end else begin
      mapped = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      prdata_r  <= '0;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r  <= i_apb.pwrite ? 32'h0000_0000 : rd_nxt;
      pslverr_r <= !mapped;
    end
  end

  assign o_apb.prdata  = prdata_r;
  assign o_apb.pready  = 1'b1;
  assign o_apb.pslverr = pslverr_r;

  // ==========================================================================
  // software registers
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      reload_time_constant_r <= RST_RELOAD;
    end else if (wr_en && i_apb.paddr == OFS_RELOAD) begin
      reload_time_constant_r <= i_apb.pwdata[7:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tx_clock_source_reg_r <= RST_CSRC;
      rx_clock_source_reg_r <= RST_CSRC;
    end else if (wr_en) begin
      if (i_apb.paddr == OFS_TX_SRC) begin
        tx_clock_source_reg_r <= i_apb.pwdata[7:0];
      end else if (i_apb.paddr == OFS_RX_SRC) begin
        rx_clock_source_reg_r <= i_apb.pwdata[7:0];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mode_reg_one_r <= RST_MODE1;
    end else if (wr_en && i_apb.paddr == OFS_MODE1) begin
      mode_reg_one_r <= i_apb.pwdata[7:0];
    end
  end

  // ==========================================================================
  // reload timer; a new constant takes effect at the next reload so the
  // running period is never cut short mid-count
  assign period = (reload_time_constant_r == 8'h00) ? RELOAD_ZERO_PERIOD :
                  {1'b0, reload_time_constant_r};
  assign timer_pulse = (timer_r == TIMER_ONE);

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      timer_r <= RELOAD_ZERO_PERIOD;
    end else if (timer_pulse) begin
      timer_r <= period;
    end else begin
      timer_r <= timer_r - 9'h001;
    end
  end

  // ==========================================================================
  // per-direction divider, routing and async bit-rate scaling (0 = tx, 1 = rx)
  // constant up to 256 times exponent up to 9 spans down to clock/2^17;
  // accuracy over the usable range follows from the 8-bit constant
  assign dir_exp[0] = tx_clock_source_reg_r[EXP_LSB +: 4];
  assign dir_exp[1] = rx_clock_source_reg_r[EXP_LSB +: 4];
  assign dir_sel[0] = tx_clock_source_reg_r[SEL_LSB +: 3];
  assign dir_sel[1] = rx_clock_source_reg_r[SEL_LSB +: 3];

  assign async_mode        = mode_reg_one_r[ASYNC_BIT];
  assign async_clock_ratio = mode_reg_one_r[RATIO_LSB +: 2];
  assign ratio_term = (async_clock_ratio == RATIO_16) ? TERM_16 :
                      (async_clock_ratio == RATIO_32) ? TERM_32 : TERM_64;

  for (genvar d = 0; d < 2; d++) begin : g_dir
    logic       clk_q_r;
    logic       tick_q_r;
    logic       bit_q_r;
    logic [5:0] acnt_r;

    bgen_divider u_div (
      .i_clk   (i_clk),
      .i_rstn  (i_rstn),
      .i_pulse (timer_pulse),
      .i_exp   (dir_exp[d]),
      .o_clk   (div_clk[d]),
      .o_tick  (div_tick[d])
    );

    // an undivided full-rate clock would be a constant level to the data path
    assign fast[d]  = (reload_time_constant_r == RELOAD_FULL_RATE) &&
                      (dir_exp[d] == 4'h0);
    assign route[d] = (dir_sel[d] == CS_GEN) && !fast[d];

    always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        clk_q_r  <= 1'b0;
        tick_q_r <= 1'b0;
      end else begin
        clk_q_r  <= route[d] && div_clk[d];
        tick_q_r <= route[d] && div_tick[d];
      end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        acnt_r <= '0;
      end else if (!route[d] || !async_mode) begin
        acnt_r <= '0;
      end else if (div_tick[d]) begin
        acnt_r <= (acnt_r >= ratio_term) ? 6'h00 : acnt_r + 6'h01;
      end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        bit_q_r <= 1'b0;
      end else begin
        bit_q_r <= route[d] && div_tick[d] &&
                   (!async_mode || acnt_r >= ratio_term);
      end
    end

    assign out_clk[d]  = clk_q_r;
    assign out_tick[d] = tick_q_r;
    assign out_bit[d]  = bit_q_r;
  end

  assign o_tx.clk      = out_clk[0];
  assign o_tx.tick     = out_tick[0];
  assign o_tx.bit_tick = out_bit[0];
  assign o_rx.clk      = out_clk[1];
  assign o_rx.tick     = out_tick[1];
  assign o_rx.bit_tick = out_bit[1];

  // ==========================================================================
  // digital pll clock from the receive generator; full rate is allowed here
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pll_tick_r <= 1'b0;
    end else begin
      pll_tick_r <= (dir_sel[1] == CS_PLL) && div_tick[1];
    end
  end

  assign o_pll_tick = pll_tick_r;

  // ==========================================================================
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  a_timer_reload: assert property (
    timer_pulse |=> (timer_r == $past(period)))
    else $error("timer did not reload the programmed period");

  a_zero_period: assert property (
    (timer_pulse && reload_time_constant_r == 8'h00) |=>
      (timer_r == RELOAD_ZERO_PERIOD) ##255 timer_pulse)
    else $error("zero constant did not give a 256 clock period");

  a_full_rate: assert property (
    (timer_pulse && reload_time_constant_r == RELOAD_FULL_RATE) |=> timer_pulse)
    else $error("constant of one did not pulse every clock");

  a_reload_write: assert property (
    (wr_en && i_apb.paddr == OFS_RELOAD) |=>
      (reload_time_constant_r == $past(i_apb.pwdata[7:0])))
    else $error("reload constant write lost");

  a_fast_gated: assert property (
    (fast[0] && $past(fast[0])) |-> (!o_tx.clk && !o_tx.tick))
    else $error("full rate clock reached the transmit path");

  a_tx_route: assert property (
    (dir_sel[0] != CS_GEN) |=> (!o_tx.tick && !o_tx.bit_tick))
    else $error("transmit clock given while not selected");

  // the reset edge itself holds the count, so the first cycle is skipped
  a_timer_count: assert property (
    ($past(i_rstn) && !timer_pulse) |=> (timer_r == $past(timer_r) - 9'h001))
    else $error("reload timer did not count down by one");

  a_rx_fast_gated: assert property (
    (fast[1] && $past(fast[1])) |-> (!o_rx.clk && !o_rx.tick))
    else $error("full rate clock reached the receive path");

  a_rx_route: assert property (
    (dir_sel[1] != CS_GEN) |=> (!o_rx.tick && !o_rx.bit_tick))
    else $error("receive clock given while not selected");

  a_tx_tick_path: assert property (
    (route[0] && div_tick[0]) |=> o_tx.tick)
    else $error("transmit divider tick did not reach the output");

  a_pll_off: assert property (
    (dir_sel[1] != CS_PLL) |=> !o_pll_tick)
    else $error("pll clock given while not selected");

  a_pll_route: assert property (
    (dir_sel[1] == CS_PLL && div_tick[1]) |=> o_pll_tick)
    else $error("pll clock missing while selected");

  a_sync_bit: assert property (
    (route[0] && div_tick[0] && !async_mode) |=> o_tx.bit_tick)
    else $error("synchronous bit tick did not follow the divider");

  a_apb_answer: assert property (
    (setup && (i_apb.paddr > OFS_STAT)) |=> (o_apb.pslverr && o_apb.pready))
    else $error("unmapped address not answered with an error");

endmodule

//--- bgen_partner.sv
// far-side model: serial transmitter, receiver and pll counting clock pulses
`timescale 1ns/1ps
module bgen_partner
  import bgen_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rstn,
  input  bgen_clk_s i_tx,
  input  bgen_clk_s i_rx,
  input  wire logic i_pll_tick,
  output int        o_cnt [5],
  output int        o_gap [5]
);
  // ==========================================================================
  // pulse counters: 0 tx tick, 1 tx bit, 2 rx tick, 3 rx bit, 4 pll
  logic [4:0] ev;
  int         age [5];

  // the consumers only see single-cycle pulses, so gaps are measured in cycles
  assign ev = {i_pll_tick, i_rx.bit_tick, i_rx.tick, i_tx.bit_tick, i_tx.tick};

  always_ff @(posedge i_clk or negedge i_rstn) begin
    for (int k = 0; k < 5; k++) begin
      if (!i_rstn) begin
        o_cnt[k] <= 0;
        o_gap[k] <= 0;
        age[k]   <= 0;
      end else if (ev[k] === 1'b1) begin
        o_cnt[k] <= o_cnt[k] + 1;
        o_gap[k] <= age[k] + 1;
        age[k]   <= 0;
      end else begin
        age[k]   <= age[k] + 1;
      end
    end
  end
endmodule

//--- bgen_top_tb.sv
// self-checking testbench of the baud rate generator
`timescale 1ns/1ps
module bgen_top_tb
  import bgen_pkg::*;
;
  logic          i_clk;
  logic          i_rstn;
  bgen_apb_req_s req;
  bgen_apb_rsp_s rsp;
  bgen_clk_s     tx;
  bgen_clk_s     rx;
  logic          pll_tick;
  int            cnt [5];
  int            gap [5];
  int            bad_count;
  int            checks;
  logic [31:0]   rd;
  logic          err;

  bgen_top dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_apb(req), .o_apb(rsp),
                .o_tx(tx), .o_rx(rx), .o_pll_tick(pll_tick));
  bgen_partner far (.i_clk(i_clk), .i_rstn(i_rstn), .i_tx(tx), .i_rx(rx),
                    .i_pll_tick(pll_tick), .o_cnt(cnt), .o_gap(gap));

  always #2.5 i_clk = ~i_clk;

  // ==========================================================================
  // helpers
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // one apb transfer; an idle edge follows so back-to-back calls never collide
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= wr;
    req.paddr   <= a;
    req.pwdata  <= wd;
    @(posedge i_clk);
    req.penable <= 1'b1;
    // only the watchdog ends a wait for the slave
    do begin
      @(posedge i_clk);
    end while (rsp.pready !== 1'b1);
    rd  = rsp.prdata;
    err = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
    @(posedge i_clk);
  endtask

  task automatic cfg(input logic [7:0] reload, tx_src, rx_src, mode1);
    apb(1'b1, OFS_RELOAD, {24'h00_0000, reload});
    apb(1'b1, OFS_TX_SRC, {24'h00_0000, tx_src});
    apb(1'b1, OFS_RX_SRC, {24'h00_0000, rx_src});
    apb(1'b1, OFS_MODE1, {24'h00_0000, mode1});
  endtask

  task automatic wait_ev(input int k, input int n, input int lim);
    int c0;
    int t;
    c0 = cnt[k];
    t  = 0;
    while (cnt[k] < c0 + n && t < lim) begin
      @(posedge i_clk);
      t++;
    end
    checks++;
    if (t >= lim) begin
      bad_count++;
      $display("Error pulse count %0d expected %0d seen %0d", k, c0 + n, cnt[k]);
    end
  endtask

  // high cycles of both bit clock levels over n consecutive cycles
  task automatic hi_cnt(input int n, output int h_tx, output int h_rx);
    h_tx = 0;
    h_rx = 0;
    repeat (n) begin
      @(posedge i_clk);
      h_tx += int'(tx.clk === 1'b1);
      h_rx += int'(rx.clk === 1'b1);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_regs();
    logic [7:0] a [4] = '{OFS_RELOAD, OFS_TX_SRC, OFS_RX_SRC, OFS_MODE1};
    foreach (a[i]) begin
      apb(1'b0, a[i], 32'h0000_0000);
      chk("reset value", 32'h0000_0000, rd);
      chk("reset err", 32'h0000_0000, {31'h0000_0000, err});
    end
    apb(1'b1, OFS_RELOAD, 32'hFFFF_FFA5);
    apb(1'b0, OFS_RELOAD, 32'h0000_0000);
    chk("constant readback", 32'h0000_00A5, rd);
    apb(1'b0, 8'h14, 32'h0000_0000);
    chk("unmapped data", 32'h0000_0000, rd);
    chk("unmapped err", 32'h0000_0001, {31'h0000_0000, err});
    apb(1'b1, OFS_STAT, 32'h0000_0055);
    chk("status write err", 32'h0000_0001, {31'h0000_0000, err});
    $display("test regs done");
  endtask

  task automatic t_rate();
    int ht;
    int hr;
    cfg(8'h03, 8'h41, 8'h40, 8'h00);
    wait_ev(0, 3, 1000);
    chk("tx period", 32'h0000_0006, gap[0]);
    chk("tx bit period", 32'h0000_0006, gap[1]);
    hi_cnt(6, ht, hr);
    chk("tx clk high", 32'h0000_0003, ht);
    chk("rx clk high", 32'h0000_0002, hr);
    wait_ev(2, 3, 100);
    chk("rx period", 32'h0000_0003, gap[2]);
    $display("test rate done");
  endtask

  task automatic t_zero();
    int c;
    int ht;
    int hr;
    cfg(8'h00, 8'h40, 8'h00, 8'h00);
    c = cnt[2];
    wait_ev(0, 3, 1200);
    chk("zero period", 32'h0000_0100, gap[0]);
    chk("rx off count", c, cnt[2]);
    hi_cnt(8, ht, hr);
    chk("rx clk off", 32'h0000_0000, hr);
    $display("test zero done");
  endtask

  task automatic t_full();
    int c;
    int c4;
    cfg(8'h01, 8'h40, 8'h60, 8'h00);
    wait_ev(4, 3, 600);
    chk("pll period", 32'h0000_0001, gap[4]);
    c  = cnt[0];
    c4 = cnt[4];
    repeat (20) @(posedge i_clk);
    chk("full rate tx", c, cnt[0]);
    chk("pll pulses", c4 + 20, cnt[4]);
    // timer 1, both bit clocks low, both directions flagged full rate
    apb(1'b0, OFS_STAT, 32'h0000_0000);
    chk("status fast", 32'h0000_1801, rd);
    chk("status err", 32'h0000_0000, {31'h0000_0000, err});
    $display("test full done");
  endtask

  task automatic t_exp9();
    int ht;
    int hr;
    // 4'hF is above the top exponent and is clamped to nine
    cfg(8'h01, 8'h4F, 8'h49, 8'h00);
    wait_ev(0, 3, 2000);
    chk("tx max exp", 32'h0000_0200, gap[0]);
    hi_cnt(512, ht, hr);
    chk("tx clk half", 32'h0000_0100, ht);
    chk("rx clk half", 32'h0000_0100, hr);
    wait_ev(2, 2, 1200);
    chk("rx max exp", 32'h0000_0200, gap[2]);
    $display("test exp9 done");
  endtask

  task automatic t_async();
    // ratio codes 2 and 3 both select the slowest ratio
    for (int r = 0; r < 4; r++) begin
      cfg(8'h02, 8'h40, 8'h40, {r[1:0], 6'h01});
      wait_ev(1, 3, 800);
      chk("tx async bit", 32'h0000_0020 << ((r > 2) ? 2 : r), gap[1]);
      wait_ev(3, 2, 400);
      chk("rx async bit", 32'h0000_0020 << ((r > 2) ? 2 : r), gap[3]);
    end
    $display("test async done");
  endtask

  // ==========================================================================
  // main sequence and watchdog
  initial begin
    i_clk     = 1'b0;
    i_rstn    = 1'b0;
    req       = '0;
    bad_count = 0;
    checks    = 0;
    repeat (12) @(posedge i_clk);
    i_rstn <= 1'b1;
    @(posedge i_clk);
    t_regs();
    t_rate();
    t_zero();
    t_full();
    t_exp9();
    t_async();
    wrap_up();
  end

  initial begin
    // all scenarios together need well under twenty thousand cycles
    repeat (50000) @(posedge i_clk);
    bad_count++;
    wrap_up();
  end
endmodule
